// *** hw/sfc_cmd.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - busy-output enable opcode makes the serial output report busy during word programming
// - in that mode, chip select low drives busy on output: low busy, high ready
// - releasing chip select in that mode floats the serial output
// - in hardware-indication word programming only word-program and write-disable are taken
// - leave mode by write-disable, then busy-output disable
// - sector erase with address sets the 4 KB sector selected by upper bits
// - sector or block erase onto a protected area is ignored
// - 32 KB block erase with address sets the selected block to ones
// - 64 KB block erase with address sets the selected block to ones
// - two chip erase opcodes, no address, set the whole array to ones
// - chip erase is ignored when any area is protected
// - erase starts only after chip select rises at the end of the frame
// - read-status is answered at any time outside hardware-indication mode, even while busy
// - read-status repeats status bytes until chip select rises
// - write-enable sets the write enable latch, permitting program and erase
// - a status write ending with chip select rising clears the write enable latch
// - write-disable clears the write enable latch and the auto-increment flag
// - write-disable does not abort a running program
// - write-enable and write-disable act only when chip select rises after the opcode
// - read-status opcode also valid in word programming with software detection
// - word step: opcode, first step address, then even then odd data byte
module sfc_cmd #(
	parameter int SE_CYC = sfc_pkg::SECTOR_ERASE_CYC,
	parameter int BE_CYC = sfc_pkg::BLOCK_ERASE_CYC,
	parameter int CE_CYC = sfc_pkg::CHIP_ERASE_CYC,
	parameter int BP_CYC = sfc_pkg::BYTE_PROGRAM_CYC
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE_N,
	input wire logic SCK,
	input wire logic SI,
	input wire logic PROT_EN,
	input wire logic [23:0] PROT_BOUND,
	output logic SO,
	output logic SO_OE,
	output logic BUSY,
	output logic WRITE_ENABLE_LATCH,
	output logic AUTO_INCREMENT_PROGRAM,
	output logic ERASE_STB,
	output logic [1:0] ERASE_KIND,
	output logic [23:0] ERASE_BASE,
	output logic PROG_STB,
	output logic [23:0] PROG_ADDR,
	output logic [15:0] PROG_DATA
);

	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic ce_n_s, sck_s, si_s;
	logic ce_d_r, sck_d_r;

	sfc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
		.clk(CLK),
		.rst(RST),
		.d({CE_N, SCK, SI}),
		.q({ce_n_s, sck_s, si_s})
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			ce_d_r <= 1'b1;
			sck_d_r <= 1'b0;
		end else begin
			ce_d_r <= ce_n_s;
			sck_d_r <= sck_s;
		end
	end

	wire ce_fall = ce_d_r & ~ce_n_s;
	wire ce_rise = ~ce_d_r & ce_n_s;
	wire sck_rise = ~ce_n_s & sck_s & ~sck_d_r;
	wire sck_fall = ~ce_n_s & ~sck_s & sck_d_r;

	// ----------------------------------------
	// frame shifter
	// ----------------------------------------
	logic [sfc_pkg::SHIFT_W-1:0] shift_r;
	logic [5:0] cnt_r;
	logic [7:0] op_r;

	// msb first, sampled on rising serial clock
	always_ff @(posedge CLK) begin
		if (RST) begin
			shift_r <= '0;
			cnt_r <= '0;
			op_r <= '0;
		end else if (ce_fall) begin
			cnt_r <= '0;
		end else if (sck_rise) begin
			shift_r <= {shift_r[sfc_pkg::SHIFT_W-2:0], si_s};
			if (cnt_r != sfc_pkg::CNT_MAX)
				cnt_r <= cnt_r + 6'h01;
			if (cnt_r == sfc_pkg::LEN_OP - 6'h01)
				op_r <= {shift_r[6:0], si_s};
		end
	end

	// ----------------------------------------
	// decode at chip select rise
	// ----------------------------------------
	logic wel_r, aai_r, bso_r, aai_top_r;
	logic [23:0] aai_addr_r;
	logic [sfc_pkg::TMR_W-1:0] busy_cnt_r;

	wire busy_w = busy_cnt_r != '0;
	wire len8 = cnt_r == sfc_pkg::LEN_OP;
	wire len16 = cnt_r == sfc_pkg::LEN_STATUS_WRITE;
	wire len24 = cnt_r == sfc_pkg::LEN_AAI_NEXT;
	wire len32 = cnt_r == sfc_pkg::LEN_ADDR_CMD;
	wire len48 = cnt_r == sfc_pkg::LEN_AAI_FIRST;
	wire gate_norm = ce_rise & ~busy_w & ~aai_r;
	wire gate_aai = ce_rise & ~busy_w & aai_r;
	wire hw_mode_w = bso_r & aai_r;

	wire op_sec = op_r == sfc_pkg::OP_SECTOR_ERASE;
	wire op_b32 = op_r == sfc_pkg::OP_BLOCK32_ERASE;
	wire op_b64 = op_r == sfc_pkg::OP_BLOCK64_ERASE;
	wire op_chip = (op_r == sfc_pkg::OP_CHIP_ERASE_A) | (op_r == sfc_pkg::OP_CHIP_ERASE_B);
	wire op_aai = op_r == sfc_pkg::OP_AUTO_INC;

	// write latch commands act only at chip select rise
	wire do_write_enable_cmd = gate_norm & len8 & (op_r == sfc_pkg::OP_WRITE_ENABLE);
	wire do_write_disable_cmd = ce_rise & len8 & (op_r == sfc_pkg::OP_WRITE_DISABLE);
	wire do_ebsy = gate_norm & len8 & (op_r == sfc_pkg::OP_BUSY_OUT_EN);
	wire do_busy_output_disable_cmd = gate_norm & len8 & (op_r == sfc_pkg::OP_BUSY_OUT_DIS);
	wire do_status_write_cmd = gate_norm & len16 & wel_r & (op_r == sfc_pkg::OP_STATUS_WRITE);

	// region selection by upper address bits
	wire [23:0] cmd_addr = shift_r[23:0];
	wire [23:0] erase_mask = op_sec ? sfc_pkg::SECTOR_MASK :
		op_b32 ? sfc_pkg::BLOCK32_MASK :
		op_b64 ? sfc_pkg::BLOCK64_MASK : sfc_pkg::CHIP_MASK;
	wire [1:0] erase_kind = op_sec ? sfc_pkg::EK_SECTOR :
		op_b32 ? sfc_pkg::EK_BLOCK32 :
		op_b64 ? sfc_pkg::EK_BLOCK64 : sfc_pkg::EK_CHIP;
	wire [23:0] erase_base = op_chip ? '0 : (cmd_addr & ~erase_mask);
	wire [23:0] erase_top = erase_base | erase_mask;

	// protected when the region reaches the bound; chip always does
	wire erase_prot = PROT_EN & (erase_top >= PROT_BOUND);
	wire erase_len = ((op_sec | op_b32 | op_b64) & len32) | (op_chip & len8);
	// latch gates the start, which waits for chip select rise
	wire erase_go = gate_norm & wel_r & erase_len & ~erase_prot;

	// word programming steps
	wire [23:0] first_addr = {shift_r[39:17], 1'b0};
	wire aai_first = gate_norm & wel_r & op_aai & len48
		& ~(PROT_EN & (first_addr >= PROT_BOUND));
	wire aai_next = gate_aai & wel_r & op_aai & len24 & ~aai_top_r
		& ~(PROT_EN & (aai_addr_r >= PROT_BOUND));
	wire [23:0] step_addr = aai_first ? first_addr : aai_addr_r;
	wire prog_go = aai_first | aai_next;

	// ----------------------------------------
	// latches and mode flags
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			wel_r <= 1'b0;
			aai_r <= 1'b0;
			bso_r <= 1'b0;
			aai_top_r <= 1'b0;
			aai_addr_r <= '0;
		end else begin
			if (do_write_enable_cmd)
				wel_r <= 1'b1;
			else if (do_write_disable_cmd | do_status_write_cmd | erase_go)
				wel_r <= 1'b0;
			if (do_write_disable_cmd)
				aai_r <= 1'b0;
			else if (aai_first)
				aai_r <= 1'b1;
			if (do_ebsy)
				bso_r <= 1'b1;
			else if (do_busy_output_disable_cmd)
				bso_r <= 1'b0;
			// no wrap at the top of the array
			if (prog_go) begin
				aai_addr_r <= step_addr + sfc_pkg::WORD_STEP;
				aai_top_r <= &step_addr[23:1];
			end
		end
	end

	// ----------------------------------------
	// self-timed operation
	// ----------------------------------------
	// write-disable never touches the timer
	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_cnt_r <= '0;
		end else if (erase_go) begin
			if (op_chip)
				busy_cnt_r <= sfc_pkg::TMR_W'(CE_CYC);
			else if (op_sec)
				busy_cnt_r <= sfc_pkg::TMR_W'(SE_CYC);
			else
				busy_cnt_r <= sfc_pkg::TMR_W'(BE_CYC);
		end else if (prog_go) begin
			busy_cnt_r <= sfc_pkg::TMR_W'(BP_CYC);
		end else if (busy_w) begin
			busy_cnt_r <= busy_cnt_r - 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ERASE_STB <= 1'b0;
			ERASE_KIND <= '0;
			ERASE_BASE <= '0;
			PROG_STB <= 1'b0;
			PROG_ADDR <= '0;
			PROG_DATA <= '0;
		end else begin
			ERASE_STB <= erase_go;
			PROG_STB <= prog_go;
			if (erase_go) begin
				ERASE_KIND <= erase_kind;
				ERASE_BASE <= erase_base;
			end
			if (prog_go) begin
				PROG_ADDR <= step_addr;
				PROG_DATA <= shift_r[15:0];
			end
		end
	end

	// ----------------------------------------
	// serial output
	// ----------------------------------------
	logic [7:0] status_w;
	logic so_r;
	logic [2:0] out_idx_r;

	always_comb begin
		status_w = '0;
		status_w[sfc_pkg::ST_BUSY] = busy_w;
		status_w[sfc_pkg::ST_WEL] = wel_r;
		status_w[sfc_pkg::ST_AAI] = aai_r;
	end

	// read-status not taken in hardware-indication mode
	// stale opcode and count linger for the select edge itself, so mask it
	wire rd_active = (op_r == sfc_pkg::OP_READ_STATUS) & (cnt_r >= sfc_pkg::LEN_OP)
		& ~ce_fall & ~hw_mode_w;

	// status bytes repeat while the clock runs, busy or not
	always_ff @(posedge CLK) begin
		if (RST) begin
			so_r <= 1'b1;
			out_idx_r <= sfc_pkg::ST_MSB;
		end else if (ce_fall) begin
			out_idx_r <= sfc_pkg::ST_MSB;
		end else if (sck_fall & rd_active) begin
			so_r <= status_w[out_idx_r];
			out_idx_r <= out_idx_r - 3'h1;
		end
	end

	// low while busy, released with chip select
	assign SO = hw_mode_w ? ~busy_w : so_r;
	assign SO_OE = ~ce_n_s & (hw_mode_w | rd_active);
	assign BUSY = busy_w;
	assign WRITE_ENABLE_LATCH = wel_r;
	assign AUTO_INCREMENT_PROGRAM = aai_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	AST_EBSY_SETS_MODE: assert property (
		do_ebsy |=> bso_r ##1 bso_r)
		else $error("busy-output enable not latched");
	AST_BUSY_ON_SO: assert property (
		(~ce_n_s & hw_mode_w) |-> (SO_OE && SO == (busy_cnt_r == '0)))
		else $error("busy not driven on serial output");
	AST_SO_FLOAT: assert property (
		$rose(ce_n_s) |-> !SO_OE)
		else $error("serial output still driven after deselect");
	AST_HW_MODE_FILTER: assert property (
		(hw_mode_w & ce_rise) |=> !ERASE_STB)
		else $error("erase taken in word programming mode");
	AST_SECTOR_ALIGN: assert property (
		(ERASE_STB && ERASE_KIND == sfc_pkg::EK_SECTOR) |-> ERASE_BASE[11:0] == 12'h000)
		else $error("sector base not aligned");
	AST_CHIP_PROTECT: assert property (
		(ERASE_STB && ERASE_KIND == sfc_pkg::EK_CHIP) |-> !$past(PROT_EN))
		else $error("chip erase despite protection");
	AST_ERASE_AT_RISE: assert property (
		$rose(ERASE_STB) |-> ($past(ce_rise) && $past(wel_r) && BUSY))
		else $error("erase started without deselect or latch");
	AST_WRITE_DISABLE_CMD_CLEARS: assert property (
		do_write_disable_cmd |=> (!WRITE_ENABLE_LATCH && !AUTO_INCREMENT_PROGRAM))
		else $error("write-disable left latch or flag set");
	AST_WRITE_DISABLE_CMD_NO_ABORT: assert property (
		(do_write_disable_cmd && busy_cnt_r > 32'h2) |=> BUSY [*2])
		else $error("write-disable aborted an operation");
	AST_READ_STATUS_CMD_DRIVES: assert property (
		(~ce_n_s && !ce_fall && !hw_mode_w && op_r == sfc_pkg::OP_READ_STATUS
		&& cnt_r >= sfc_pkg::LEN_OP)
		|-> SO_OE)
		else $error("read-status not driven");

	COV_ERASE: cover property (ERASE_STB);
	COV_PROG_STEP: cover property (PROG_STB ##[1:1000] PROG_STB);
	COV_READ_STATUS_CMD_BUSY: cover property (rd_active && BUSY && sck_fall);
	COV_HW_READY: cover property (SO_OE && hw_mode_w && SO);

endmodule

// *** include/sfc_pkg.sv ***
package sfc_pkg;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
	localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_AUTO_INC = 8'had;

	// ----------------------------------------
	// frame lengths in bits
	// ----------------------------------------
	localparam int CNT_W = 6;
	localparam logic [5:0] LEN_OP = 6'h08;
	localparam logic [5:0] LEN_STATUS_WRITE = 6'h10;
	localparam logic [5:0] LEN_AAI_NEXT = 6'h18;
	localparam logic [5:0] LEN_ADDR_CMD = 6'h20;
	localparam logic [5:0] LEN_AAI_FIRST = 6'h30;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	localparam int SHIFT_W = 48;

	// ----------------------------------------
	// address and erase regions
	// ----------------------------------------
	localparam int ADDR_W = 24;
	localparam logic [23:0] SECTOR_MASK = 24'h000fff;
	localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
	localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
	localparam logic [23:0] CHIP_MASK = 24'hffffff;
	localparam logic [23:0] WORD_STEP = 24'h000002;
	localparam logic [1:0] EK_SECTOR = 2'h0;
	localparam logic [1:0] EK_BLOCK32 = 2'h1;
	localparam logic [1:0] EK_BLOCK64 = 2'h2;
	localparam logic [1:0] EK_CHIP = 2'h3;

	// ----------------------------------------
	// status byte
	// ----------------------------------------
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_AAI = 6;
	localparam logic [2:0] ST_MSB = 3'h7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SECTOR_ERASE_TIME_US = 25000;
	localparam int BLOCK_ERASE_TIME_US = 25000;
	localparam int CHIP_ERASE_TIME_US = 50000;
	localparam int BYTE_PROGRAM_TIME_US = 10;
	localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_MHZ;
	localparam int BYTE_PROGRAM_CYC = BYTE_PROGRAM_TIME_US * CLK_MHZ;
	localparam int TMR_W = 32;

endpackage

// *** hw/sfc_sync.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module sfc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

// *** test/sfc_host.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// host side serial master, mode 0
// ----------------------------------------
module sfc_host (
	input wire logic clk,
	input wire logic so,
	output logic ce_n,
	output logic sck,
	output logic si
);
	// sck stands low outside frames, no free-running clock
	initial begin
		ce_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
		#2;
	endtask
	// msb first, bit set up while sck is low
	task automatic frame(input logic [47:0] d, input int n, input int nrd, output logic [15:0] rd);
		rd = '0;
		ce_n = 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			si = d[i];
			half();
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
		for (int i = 0; i < nrd; i++) begin
			si = ~si;
			half();
			sck = 1'b1;
			half();
			rd = {rd[14:0], so};
			sck = 1'b0;
		end
		half();
		ce_n = 1'b1;
		si = ~si;
		repeat (8) @(posedge clk);
		#2;
	endtask
	// select without clocking, to watch the busy pin
	task automatic select(input logic on);
		ce_n = ~on;
		repeat (8) @(posedge clk);
		#2;
	endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
	logic clk, rst, prot_en, ce_n, sck, si, so, so_oe, busy, write_enable_latch, auto_increment_program, erase_stb, prog_stb;
	logic so_last, so_line;
	logic [1:0] erase_kind;
	logic [23:0] prot_bound, erase_base, prog_addr, addr;
	logic [15:0] prog_data, dat, rd;
	logic [33:0] r;
	int fails = 0;
	int total_checks = 0;
	int n_erase = 0;
	int n_prog = 0;
	int ne, np;
	integer seed = 82;

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	sfc_cmd #(.SE_CYC(300), .BE_CYC(320), .CE_CYC(360)) uut (.CLK(clk),
		.RST(rst), .CE_N(ce_n), .SCK(sck), .SI(si), .PROT_EN(prot_en),
		.PROT_BOUND(prot_bound), .SO(so), .SO_OE(so_oe), .BUSY(busy), .WRITE_ENABLE_LATCH(write_enable_latch),
		.AUTO_INCREMENT_PROGRAM(auto_increment_program), .ERASE_STB(erase_stb), .ERASE_KIND(erase_kind),
		.ERASE_BASE(erase_base), .PROG_STB(prog_stb), .PROG_ADDR(prog_addr),
		.PROG_DATA(prog_data));
	// floating line reads as the inverse of its last driven level
	assign so_line = so_oe ? so : ~so_last;
	sfc_host u_host (.clk(clk), .so(so_line), .ce_n(ce_n), .sck(sck), .si(si));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rst) so_last <= 1'b0;
		else so_last <= so_oe ? so : so_last;
		if (erase_stb === 1'b1) n_erase <= n_erase + 1;
		if (prog_stb === 1'b1) n_prog <= n_prog + 1;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cmd(input logic [47:0] d, input int n);
		logic [15:0] x;
		u_host.frame(d, n, 0, x);
	endtask
	task automatic wait_idle();
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 2000) begin
			@(posedge clk);
			i++;
		end
		#2;
		if (busy !== 1'b0) check(busy, 1'b0);
	endtask
	// kind, opcode and ignored low address bits of each erase
	function automatic logic [33:0] erow(input int k);
		case (k)
			0: erow = {sfc_pkg::EK_SECTOR, sfc_pkg::OP_SECTOR_ERASE, sfc_pkg::SECTOR_MASK};
			1: erow = {sfc_pkg::EK_BLOCK32, sfc_pkg::OP_BLOCK32_ERASE, sfc_pkg::BLOCK32_MASK};
			2: erow = {sfc_pkg::EK_BLOCK64, sfc_pkg::OP_BLOCK64_ERASE, sfc_pkg::BLOCK64_MASK};
			3: erow = {sfc_pkg::EK_CHIP, sfc_pkg::OP_CHIP_ERASE_A, sfc_pkg::CHIP_MASK};
			default: erow = {sfc_pkg::EK_CHIP, sfc_pkg::OP_CHIP_ERASE_B, sfc_pkg::CHIP_MASK};
		endcase
	endfunction
	task automatic give_verdict();
		if (fails == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		#1500000;
		fails++;
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		prot_en = 1'b0;
		prot_bound = 24'h800000;
		repeat (12) @(posedge clk);
		#2 rst = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		check({busy, write_enable_latch, auto_increment_program, so_oe}, 4'h0);
		cmd(48'h0600, 16);
		check(write_enable_latch, 1'b0);
		cmd(48'h06, 8);
		check(write_enable_latch, 1'b1);
		cmd(48'h0100, 16);
		check(write_enable_latch, 1'b0);
		for (int k = 0; k < 5; k++) begin
			r = erow(k);
			addr = 24'($random(seed));
			cmd(48'h06, 8);
			ne = n_erase;
			if (k < 3) cmd({16'h0, r[31:24], addr}, 32);
			else cmd({40'h0, r[31:24]}, 8);
			check(n_erase, ne + 1);
			check(erase_kind, r[33:32]);
			check(erase_base, (k < 3) ? (addr & ~r[23:0]) : 24'h0);
			check({busy, write_enable_latch}, 2'b10);
			u_host.frame(48'h05, 8, 16, rd);
			check(rd, 16'h0101);
			wait_idle();
		end
		ne = n_erase;
		cmd({16'h0, sfc_pkg::OP_SECTOR_ERASE, addr}, 32);
		check(n_erase, ne);
		// random bound, above the block below and beneath the sector below
		prot_bound = 24'h400000 | (24'($random(seed)) & 24'h3fffff);
		prot_en = 1'b1;
		cmd(48'h06, 8);
		cmd({16'h0, sfc_pkg::OP_SECTOR_ERASE, 24'h9abcde}, 32);
		check(n_erase, ne);
		cmd({40'h0, sfc_pkg::OP_CHIP_ERASE_A}, 8);
		check(n_erase, ne);
		cmd({16'h0, sfc_pkg::OP_BLOCK32_ERASE, 24'h012345}, 32);
		check(n_erase, ne + 1);
		check(erase_base, 24'h010000);
		wait_idle();
		prot_en = 1'b0;
		cmd(48'h06, 8);
		cmd(48'h04, 8);
		check(write_enable_latch, 1'b0);
		// hardware busy indication on the serial output
		cmd(48'h70, 8);
		cmd(48'h06, 8);
		addr = 24'($random(seed)) & 24'h7ffffe;
		dat = 16'($random(seed));
		np = n_prog;
		cmd({sfc_pkg::OP_AUTO_INC, addr, dat}, 48);
		check(n_prog, np + 1);
		check({prog_addr, prog_data}, {addr, dat});
		check({auto_increment_program, busy}, 2'b11);
		u_host.select(1'b1);
		check({so_oe, so}, 2'b10);
		wait_idle();
		check({so_oe, so}, 2'b11);
		u_host.select(1'b0);
		check(so_oe, 1'b0);
		ne = n_erase;
		cmd({16'h0, sfc_pkg::OP_SECTOR_ERASE, addr}, 32);
		check(n_erase, ne);
		dat = 16'($random(seed));
		cmd({24'h0, sfc_pkg::OP_AUTO_INC, dat}, 24);
		check({prog_addr, prog_data}, {addr + 24'h2, dat});
		cmd(48'h04, 8);
		check({busy, auto_increment_program, write_enable_latch}, 3'b100);
		wait_idle();
		cmd(48'h80, 8);
		cmd(48'h06, 8);
		cmd({sfc_pkg::OP_AUTO_INC, addr + 24'h10, dat}, 48);
		u_host.select(1'b1);
		check(so_oe, 1'b0);
		u_host.select(1'b0);
		cmd(48'h04, 8);
		wait_idle();
		give_verdict();
	end
endmodule
